// ---- design/eee_pkg.sv ----
// Package for the energy-efficient idle control block: register map, fields, resets and timing
package eee_pkg;

  // ----------------------------------------------------------------
  // Register indices; the bus byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [11:0] RecoveryOffset = 12'h0F2; // Port 2 recovery wait
  localparam logic [11:0] NextPageOffset = 12'h0F3; // Next page enable control
  localparam logic [11:0] IdleWaitOffset = 12'h0F4; // Empty queue idle wait
  localparam logic [11:0] LoadThrOffset = 12'h0F6; // Buffer load exit threshold
  localparam logic [11:0] EeeCtrlOffset = 12'h0F8; // Enable and status (added)

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] RecoveryReset = 8'h27;
  localparam logic [1:0] NextPageReset = 2'h3;
  localparam logic [15:0] IdleWaitReset = 16'h03E8;
  localparam logic [7:0] LoadThrReset = 8'h40;
  localparam int NextPagePort1Bit = 0;
  localparam int NextPagePort2Bit = 1;
  localparam int EeeEnableBit = 0;
  localparam int StatusReqLsb = 8;
  localparam int StatusExitBit = 12;
  localparam int StatusHoldBit = 13;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int ClkPeriodPs = 10000;
  localparam int RecoveryUnitPs = 640000; // 640 ns
  localparam int RecoveryUnitCycles = (RecoveryUnitPs + ClkPeriodPs - 1) / ClkPeriodPs;
  localparam int IdleUnitNs = 1300000; // 1.3 ms
  localparam int IdleUnitCycles = (IdleUnitNs * 1000 + ClkPeriodPs - 1) / ClkPeriodPs;

  // Per-port traffic status
  typedef struct packed {
    logic queueEmpty; // Transmit queue holds nothing
    logic frameIn; // A frame enters the transmit queue this cycle
  } eee_port_t;

endpackage

// ---- design/eee_idle_timer.sv ----
// Empty transmit queue timer for one port
`timescale 1ns/1ps
module eee_idle_timer #(
  parameter int UnitCycles = 130000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire eee_pkg::eee_port_t port,
  input wire logic [15:0] waitUnits,
  output logic idleReq
);

  // ----------------------------------------------------------------
  // Prescaler and unit counter
  // ----------------------------------------------------------------
  logic [31:0] preCount; // Cycles within one wait unit
  logic [16:0] unitCount; // Whole units of emptiness seen
  logic [31:0] next_preCount;
  logic [16:0] next_unitCount;
  logic next_idleReq;

  // Count continuous emptiness, restart on a new frame
  always_comb
  begin
    next_preCount = preCount;
    next_unitCount = unitCount;
    if (!enable || !port.queueEmpty || port.frameIn)
    begin
      next_preCount = 32'h0000_0000;
      next_unitCount = 17'h0_0000;
    end
    else if (unitCount <= {1'b0, waitUnits})
    begin
      if (preCount == 32'(UnitCycles - 1))
      begin
        next_preCount = 32'h0000_0000;
        next_unitCount = unitCount + 17'h0_0001;
      end
      else
      begin
        next_preCount = preCount + 32'h0000_0001;
      end
    end
    // Request once the wait has been exceeded
    next_idleReq = enable && port.queueEmpty && !port.frameIn
                   && (unitCount > {1'b0, waitUnits});
  end

  // Register state
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      preCount <= 32'h0000_0000;
      unitCount <= 17'h0_0000;
      idleReq <= 1'b0;
    end
    else
    begin
      preCount <= next_preCount;
      unitCount <= next_unitCount;
      idleReq <= next_idleReq;
    end
  end

endmodule

// ---- design/eee_lpi_control.sv ----
// Low power idle entry and exit control with APB registers
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Operation
// - Port 2 waits recovery count times 640ns
// - Next page bit per port enables exchange
// - Request idle after queue empty past wait
// - Wait acts only with EEE enabled
// - One wait value shared by all ports
// - Any port over threshold ends idle everywhere
module eee_lpi_control #(
  parameter int NumPorts = 3,
  parameter int IdleUnitCycles = eee_pkg::IdleUnitCycles,
  parameter int RecoveryUnitCycles = eee_pkg::RecoveryUnitCycles,
  parameter int LoadWidth = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire eee_pkg::eee_port_t [NumPorts-1:0] portStat,
  input wire logic [LoadWidth-1:0] bufLoad [NumPorts],
  input wire logic port2IdleLeft,
  output logic [NumPorts-1:0] lpiRequest,
  output logic lpiExit,
  output logic port2TxHold,
  output logic [1:0] nextPageEnable
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] recoveryWait; // Port 2 recovery count
  logic [15:0] idleWait; // Shared empty queue wait
  logic [7:0] loadThr; // Buffer load threshold
  logic eeeEnable; // 100BASE-TX EEE enable
  logic [7:0] next_recoveryWait;
  logic [1:0] next_nextPageEnable;
  logic [15:0] next_idleWait;
  logic [7:0] next_loadThr;
  logic next_eeeEnable;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic [NumPorts-1:0] idleReq; // Raw timer requests
  logic [NumPorts-1:0] next_lpiRequest;
  logic next_lpiExit;

  // Decode a register address: one aligned word per register index
  function automatic logic isReg(input logic [11:0] a, input logic [11:0] off);
    isReg = (a == {off[9:0], 2'b00});
  endfunction

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic access; // Access phase, answered on the next cycle
  logic mapped; // Address hits a register
  assign access = psel && penable && !pready;
  assign mapped = isReg(paddr, eee_pkg::RecoveryOffset) || isReg(paddr, eee_pkg::NextPageOffset)
                  || isReg(paddr, eee_pkg::IdleWaitOffset) || isReg(paddr, eee_pkg::LoadThrOffset)
                  || isReg(paddr, eee_pkg::EeeCtrlOffset);

  // Register writes and read mux
  always_comb
  begin
    next_recoveryWait = recoveryWait;
    next_nextPageEnable = nextPageEnable;
    next_idleWait = idleWait;
    next_loadThr = loadThr;
    next_eeeEnable = eeeEnable;
    next_prdata = prdata;
    next_pready = access;
    next_pslverr = access && !mapped;
    if (access && pwrite)
    begin
      if (isReg(paddr, eee_pkg::RecoveryOffset))
        next_recoveryWait = pwdata[7:0];
      if (isReg(paddr, eee_pkg::NextPageOffset))
        next_nextPageEnable = pwdata[1:0];
      if (isReg(paddr, eee_pkg::IdleWaitOffset))
        next_idleWait = pwdata[15:0];
      if (isReg(paddr, eee_pkg::LoadThrOffset))
        next_loadThr = pwdata[7:0];
      if (isReg(paddr, eee_pkg::EeeCtrlOffset))
        next_eeeEnable = pwdata[eee_pkg::EeeEnableBit];
    end
    if (access && !pwrite)
    begin
      next_prdata = 32'h0000_0000;
      if (isReg(paddr, eee_pkg::RecoveryOffset))
        next_prdata[7:0] = recoveryWait;
      if (isReg(paddr, eee_pkg::NextPageOffset))
        next_prdata[1:0] = nextPageEnable;
      if (isReg(paddr, eee_pkg::IdleWaitOffset))
        next_prdata[15:0] = idleWait;
      if (isReg(paddr, eee_pkg::LoadThrOffset))
        next_prdata[7:0] = loadThr;
      if (isReg(paddr, eee_pkg::EeeCtrlOffset))
      begin
        next_prdata[eee_pkg::EeeEnableBit] = eeeEnable;
        next_prdata[eee_pkg::StatusReqLsb +: NumPorts] = lpiRequest;
        next_prdata[eee_pkg::StatusExitBit] = lpiExit;
        next_prdata[eee_pkg::StatusHoldBit] = port2TxHold;
      end
    end
  end

  // Register the bus and control state
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      recoveryWait <= eee_pkg::RecoveryReset;
      nextPageEnable <= eee_pkg::NextPageReset;
      idleWait <= eee_pkg::IdleWaitReset;
      loadThr <= eee_pkg::LoadThrReset;
      eeeEnable <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      recoveryWait <= next_recoveryWait;
      nextPageEnable <= next_nextPageEnable;
      idleWait <= next_idleWait;
      loadThr <= next_loadThr;
      eeeEnable <= next_eeeEnable;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // Per-port empty queue timers
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NumPorts; gi++)
    begin : gPort
      eee_idle_timer #(
        .UnitCycles(IdleUnitCycles)
      ) uTimer (
        .clk(clk),
        .rst_b(rst_b),
        .enable(eeeEnable),
        .port(portStat[gi]),
        .waitUnits(idleWait),
        .idleReq(idleReq[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Buffer load exit and request gating
  // ----------------------------------------------------------------
  always_comb
  begin
    next_lpiExit = 1'b0;
    for (int i = 0; i < NumPorts; i++)
    begin
      // Threshold in 128 byte units compared to byte count
      if (32'(bufLoad[i]) > {17'h0_0000, loadThr, 7'h00})
        next_lpiExit = 1'b1;
    end
    next_lpiRequest = next_lpiExit ? '0 : idleReq;
  end

  // ----------------------------------------------------------------
  // Port 2 recovery hold
  // ----------------------------------------------------------------
  logic [7:0] recUnits; // Recovery units remaining
  logic [15:0] recPre; // Cycles within a 640 ns unit
  logic [7:0] next_recUnits;
  logic [15:0] next_recPre;
  logic next_port2TxHold;

  // Load on idle exit, count down in 640 ns steps
  always_comb
  begin
    next_recUnits = recUnits;
    next_recPre = recPre;
    if (port2IdleLeft)
    begin
      next_recUnits = recoveryWait;
      next_recPre = 16'h0000;
    end
    else if (recUnits != 8'h00)
    begin
      if (recPre == 16'(RecoveryUnitCycles - 1))
      begin
        next_recPre = 16'h0000;
        next_recUnits = recUnits - 8'h01;
      end
      else
      begin
        next_recPre = recPre + 16'h0001;
      end
    end
    next_port2TxHold = (next_recUnits != 8'h00);
  end

  // Register outputs and hold state
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      recUnits <= 8'h00;
      recPre <= 16'h0000;
      port2TxHold <= 1'b0;
      lpiRequest <= '0;
      lpiExit <= 1'b0;
    end
    else
    begin
      recUnits <= next_recUnits;
      recPre <= next_recPre;
      port2TxHold <= next_port2TxHold;
      lpiRequest <= next_lpiRequest;
      lpiExit <= next_lpiExit;
    end
  end

endmodule

// ---- testbench/eee_lpi_sva.sv ----
// Assertion checker for the idle entry and exit control block
`timescale 1ns/1ps
module eee_lpi_sva #(
  parameter int IdleUnitCycles = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire eee_pkg::eee_port_t [2:0] portStat,
  input wire logic [15:0] bufLoad [3],
  input wire logic port2IdleLeft,
  input wire logic [2:0] lpiRequest,
  input wire logic lpiExit,
  input wire logic port2TxHold,
  input wire logic [1:0] nextPageEnable
);
  // ----------------------------------------------------------------
  // Bus handshake and control outputs
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  pready_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
  pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
  slverr_pair_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
  hold_cause_a: assert property ($rose(port2TxHold) |-> $past(port2IdleLeft)) else $error("hold uncaused");
  hold_reload_a: assert property ($fell(port2TxHold) |-> !$past(port2IdleLeft)) else $error("hold cut short");
  req_age_a: assert property ($rose(lpiRequest[0]) |-> $past(portStat[0].queueEmpty, IdleUnitCycles))
    else $error("request too early");
  // Timer and output stage each add one register, so a request falls two edges later
  req_drop_a: assert property (!portStat[0].queueEmpty |=> ##1 !lpiRequest[0]) else $error("request kept");
  req_frame_a: assert property (portStat[1].frameIn |=> ##1 !lpiRequest[1]) else $error("request after frame");
  exit_mask_a: assert property (lpiExit |-> lpiRequest == 3'h0) else $error("request during exit");
  exit_quiet_a: assert property (bufLoad[0] == 16'h0
    && bufLoad[1] == 16'h0 && bufLoad[2] == 16'h0 |=> !lpiExit) else $error("exit without load");
  reset_state_a: assert property (disable iff (1'b0) !rst_b
    |=> lpiRequest == 3'h0 && nextPageEnable == 2'h3) else $error("reset state wrong");
  // Main scenarios reached
  cover property ($rose(lpiRequest[0]));
  cover property ($rose(lpiExit));
  cover property ($fell(port2TxHold));
endmodule

bind eee_lpi_control eee_lpi_sva #(.IdleUnitCycles(IdleUnitCycles)) eee_lpi_sva_i (
  .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .portStat(portStat), .bufLoad(bufLoad), .port2IdleLeft(port2IdleLeft), .lpiRequest(lpiRequest),
  .lpiExit(lpiExit), .port2TxHold(port2TxHold), .nextPageEnable(nextPageEnable));

// ---- testbench/eee_link_peer.sv ----
// Remote link partner model that ends low power idle on request
`timescale 1ns/1ps
module eee_link_peer #(
  parameter int Delay = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wakeReq,
  output logic port2IdleLeft
);
  int cnt; // Cycles until the partner has woken
  // Wake takes Delay cycles, then one pulse
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cnt <= 0;
      port2IdleLeft <= 1'b0;
    end
    else
    begin
      port2IdleLeft <= (cnt == 1);
      if (wakeReq && cnt == 0)
        cnt <= Delay;
      else if (cnt != 0)
        cnt <= cnt - 1;
    end
  end
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the idle entry and exit control block
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] e; logic s;} eee_row_t;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, port2IdleLeft, lpiExit, port2TxHold, wakeReq, se;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] lpiRequest;
  logic [1:0] nextPageEnable;
  logic [15:0] bufLoad [3];
  eee_pkg::eee_port_t [2:0] portStat;
  int err_total, num_checks, n;
  eee_row_t rows [9];
  eee_lpi_control #(.IdleUnitCycles(4), .RecoveryUnitCycles(2)) eee_lpi_control_i (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .portStat(portStat),
    .bufLoad(bufLoad), .port2IdleLeft(port2IdleLeft), .lpiRequest(lpiRequest), .lpiExit(lpiExit),
    .port2TxHold(port2TxHold), .nextPageEnable(nextPageEnable));
  eee_link_peer eee_link_peer_i (.clk(clk), .rst_b(rst_b), .wakeReq(wakeReq), .port2IdleLeft(port2IdleLeft));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; waits for pready, then releases
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
    begin
      @(posedge clk);
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    wrap_up();
  end
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    {rst_b, psel, penable, pwrite, wakeReq} = 5'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    portStat = 6'h2A;
    bufLoad = '{3{16'h0}};
    err_total = 0;
    num_checks = 0;
    // Byte addresses are four times the register index; an unmapped read returns zero
    rows = '{'{1'b0, 12'h3C8, 32'h0, 32'h27, 1'b0}, '{1'b0, 12'h3CC, 32'h0, 32'h3, 1'b0},
      '{1'b0, 12'h3D0, 32'h0, 32'h3E8, 1'b0}, '{1'b0, 12'h3D8, 32'h0, 32'h40, 1'b0},
      '{1'b0, 12'h3E0, 32'h0, 32'h0, 1'b0}, '{1'b1, 12'h3CC, 32'h0, 32'h0, 1'b0},
      '{1'b1, 12'h3D0, 32'hFFFF, 32'hFFFF, 1'b0}, '{1'b0, 12'h3F0, 32'h0, 32'h0, 1'b1},
      '{1'b1, 12'h3D8, 32'hFF05, 32'h5, 1'b0}};
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rows[i])
    begin
      if (rows[i].w)
        apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk("read data", rows[i].e, rd);
      chk("slave error", {31'h0, rows[i].s}, {31'h0, se});
    end
    chk("next page off", 32'h0, {30'h0, nextPageEnable});
    apb(1'b1, 12'h3CC, 32'h2);
    chk("next page port2", 32'h2, {30'h0, nextPageEnable});
    // Idle request after wait of 2 units, frame on port 1 midway
    apb(1'b1, 12'h3D0, 32'h2);
    apb(1'b1, 12'h3E0, 32'h1);
    n = 0;
    while (lpiRequest[0] !== 1'b1 && n < 100)
    begin
      portStat[1] <= (n == 5) ? 2'h3 : 2'h2;
      @(posedge clk);
      n++;
    end
    chk("idle wait", 32'h1, {31'h0, n >= 9 && n <= 13});
    chk("shared wait", 32'h1, {31'h0, lpiRequest[2]});
    chk("frame restart", 32'h0, {31'h0, lpiRequest[1]});
    portStat[0] <= 2'h0;
    repeat (8) @(posedge clk);
    chk("late port", 32'h1, {31'h0, lpiRequest[1]});
    chk("busy queue", 32'h0, {31'h0, lpiRequest[0]});
    portStat[0] <= 2'h2;
    // Exit on buffer load, boundary 2 * 128 bytes
    apb(1'b1, 12'h3D8, 32'h2);
    bufLoad[1] <= 16'd256;
    repeat (3) @(posedge clk);
    chk("load at limit", 32'h0, {31'h0, lpiExit});
    bufLoad[1] <= 16'd257;
    repeat (3) @(posedge clk);
    chk("load over", 32'h1, {31'h0, lpiExit});
    chk("all ports wake", 32'h0, {29'h0, lpiRequest});
    // Status word: enable bit 0 and exit bit 12 set, no requests
    apb(1'b0, 12'h3E0, 32'h0);
    chk("status exit", 32'h1001, rd);
    bufLoad[1] <= 16'd0;
    apb(1'b1, 12'h3E0, 32'h0);
    repeat (20) @(posedge clk);
    chk("disabled", 32'h0, {29'h0, lpiRequest});
    // Recovery hold of 3 units
    apb(1'b1, 12'h3C8, 32'h3);
    wakeReq <= 1'b1;
    @(posedge clk);
    wakeReq <= 1'b0;
    n = 0;
    while (port2TxHold !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    n = 0;
    while (port2TxHold === 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk("hold span", 32'd6, n);
    // Reset in mid-run
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    apb(1'b0, 12'h3C8, 32'h0);
    chk("recovery reset", 32'h27, rd);
    chk("next page reset", 32'h3, {30'h0, nextPageEnable});
    wrap_up();
  end
endmodule
